// File: hw/mig_pkg.sv
// Package for the metering input, gain and current detect block.
package mig_pkg;

    // Register indices as printed; byte address is four times the index.
    localparam logic [15:0] THRESHOLD_IDX  = 16'h1002;
    localparam logic [15:0] CTRL_ONE_IDX   = 16'h2878;
    localparam logic [15:0] CTRL_TWO_IDX   = 16'h2879;
    localparam logic [15:0] CTRL_THREE_IDX = 16'h287A;
    localparam logic [15:0] DET_CTRL_IDX   = 16'h2886;

    localparam logic [17:0] THRESHOLD_ADDR  = {THRESHOLD_IDX, 2'b00};
    localparam logic [17:0] CTRL_ONE_ADDR   = {CTRL_ONE_IDX, 2'b00};
    localparam logic [17:0] CTRL_TWO_ADDR   = {CTRL_TWO_IDX, 2'b00};
    localparam logic [17:0] CTRL_THREE_ADDR = {CTRL_THREE_IDX, 2'b00};
    localparam logic [17:0] DET_CTRL_ADDR   = {DET_CTRL_IDX, 2'b00};

    // Field positions.
    localparam int VOLT_EN_BIT    = 0;
    localparam int CUR1_EN_BIT    = 1;
    localparam int CUR2_EN_BIT    = 2;
    localparam int PWR_RMS_EN_BIT = 4;
    localparam int CUR1_EXP_LSB   = 4;
    localparam int CUR1_SIGN_BIT  = 7;
    localparam int CUR2_EXP_LSB   = 0;
    localparam int CUR2_SIGN_BIT  = 3;
    localparam int LPF_EN_BIT     = 5;
    localparam int VOLT_EXP_LSB   = 0;
    localparam int VOLT_SIGN_BIT  = 3;
    localparam int WIN_LEN_LSB    = 0;
    localparam int DET_EN_BIT     = 4;
    localparam int CLEAR_BIT      = 5;
    localparam int CAUGHT_BIT     = 6;

    // Reset values.
    localparam logic [7:0]  CTRL_ONE_RST   = 8'h00;
    localparam logic [7:0]  CTRL_TWO_RST   = 8'h00;
    localparam logic [7:0]  CTRL_THREE_RST = 8'h00;
    localparam logic [4:0]  DET_CTRL_RST   = 5'h00;
    localparam logic [31:0] THRESHOLD_RST  = 32'h0000_0000;

    // Timing and arithmetic.
    localparam int          DECIM_RATIO = 256;
    localparam logic [2:0]  EXP_MAX     = 3'h5;
    localparam int          CIC_W       = 25;
    localparam int          SAMPLE_W    = 24;
    localparam int          OUT_W       = 32;

    typedef struct packed {
        logic [7:0]  ctrl_one;
        logic [7:0]  ctrl_two;
        logic [7:0]  ctrl_three;
        logic [4:0]  det_ctrl;
        logic [31:0] threshold;
    } mig_cfg_t;

    typedef struct packed {
        logic              sign;
        logic [2:0]        exponent;
    } mig_gain_t;

endpackage

// File: hw/mig_top.sv
// Metering input gating, decimation, high-pass, digital gain and current detect.
`timescale 1ns/100ps
`default_nettype none
module mig_top
    import mig_pkg::*;
(
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    rstn_i,
    // APB slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [31:0]             paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    // Modulator streams, one bit per modulator clock
    input  wire logic                    volt_bit_i,
    input  wire logic                    cur1_bit_i,
    input  wire logic                    cur2_bit_i,
    // Processed samples
    output logic signed [OUT_W-1:0]      volt_sample_o,
    output logic signed [OUT_W-1:0]      cur1_sample_o,
    output logic signed [OUT_W-1:0]      cur2_sample_o,
    output logic                         sample_valid_o,
    output logic                         power_rms_enable_o,
    output logic                         current_caught_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0]  ctrl_one_q;
    logic [7:0]  ctrl_two_q;
    logic [7:0]  ctrl_three_q;
    logic [4:0]  det_ctrl_q;
    logic [31:0] threshold_q;
    logic        caught_q;
    logic        set_caught;
    logic        wr_en;
    logic        wr_ok;
    logic [17:0] word_addr;
    logic        mapped;

    assign word_addr = paddr_i[17:0];
    assign wr_en     = psel_i & penable_i & pwrite_i;
    assign wr_ok     = wr_en && (paddr_i[31:18] == 14'h0000);
    // Registers answer at once, so the bus never waits.
    assign pready_o  = 1'b1;
    assign mapped    = (word_addr == THRESHOLD_ADDR) || (word_addr == CTRL_ONE_ADDR) ||
                       (word_addr == CTRL_TWO_ADDR) || (word_addr == CTRL_THREE_ADDR) ||
                       (word_addr == DET_CTRL_ADDR);
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // Register writes land only with the unused upper address bits at zero; the clear strobe does not check them.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            threshold_q <= THRESHOLD_RST;
        end else if (wr_ok && word_addr == THRESHOLD_ADDR) begin
            threshold_q <= pwdata_i;
        end
    end

    // Control one holds the input enables and the power path enable.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_one_q <= CTRL_ONE_RST;
        end else if (wr_ok && word_addr == CTRL_ONE_ADDR) begin
            ctrl_one_q <= pwdata_i[7:0];
        end
    end

    // Control two holds the first current gain and the voltage gain.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_two_q <= CTRL_TWO_RST;
        end else if (wr_ok && word_addr == CTRL_TWO_ADDR) begin
            ctrl_two_q <= pwdata_i[7:0];
        end
    end

    // Control three holds the second current gain and the lowpass enable.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_three_q <= CTRL_THREE_RST;
        end else if (wr_ok && word_addr == CTRL_THREE_ADDR) begin
            ctrl_three_q <= pwdata_i[7:0];
        end
    end

    // The clear bit is a strobe and is not stored; only enable and window are kept.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            det_ctrl_q <= DET_CTRL_RST;
        end else if (wr_ok && word_addr == DET_CTRL_ADDR) begin
            det_ctrl_q <= pwdata_i[4:0];
        end
    end

    logic clear_req;
    assign clear_req = (wr_en && word_addr == DET_CTRL_ADDR && pwdata_i[CLEAR_BIT]) ||
                       !det_ctrl_q[DET_EN_BIT];

    // Set wins over a clear in the same cycle so no catch is lost.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            caught_q <= 1'b0;
        end else if (set_caught) begin
            caught_q <= 1'b1;
        end else if (clear_req) begin
            caught_q <= 1'b0;
        end
    end

    always_comb begin
        prdata_o = 32'h0000_0000;
        if (psel_i && !pwrite_i) begin
            unique case (word_addr)
                THRESHOLD_ADDR:  prdata_o = threshold_q;
                CTRL_ONE_ADDR:   prdata_o = {24'h000000, ctrl_one_q};
                CTRL_TWO_ADDR:   prdata_o = {24'h000000, ctrl_two_q};
                CTRL_THREE_ADDR: prdata_o = {24'h000000, ctrl_three_q};
                DET_CTRL_ADDR:   prdata_o = {25'h0000000, caught_q, 1'b0, det_ctrl_q};
                default:         prdata_o = 32'h0000_0000;
            endcase
        end
    end

    assign power_rms_enable_o = ctrl_one_q[PWR_RMS_EN_BIT];
    assign current_caught_o   = caught_q;

    ////////////////////////////////////////////////////////////////////////////
    // Input gating and decimation

    logic [2:0] bits_gated;
    assign bits_gated[0] = volt_bit_i & ctrl_one_q[VOLT_EN_BIT];
    assign bits_gated[1] = cur1_bit_i & ctrl_one_q[CUR1_EN_BIT];
    assign bits_gated[2] = cur2_bit_i & ctrl_one_q[CUR2_EN_BIT];

    logic [7:0] decim_cnt_q;
    logic       decim_tick;
    assign decim_tick = (decim_cnt_q == 8'(DECIM_RATIO - 1));

    // Free-running; the eight-bit counter wraps by itself at the ratio.

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            decim_cnt_q <= 8'h00;
        end else begin
            decim_cnt_q <= decim_cnt_q + 8'h01;
        end
    end

    mig_gain_t gain [3];
    // voltage gain fields
    // Voltage shares control two with the first current gain.
    assign gain[0] = '{sign: ctrl_two_q[VOLT_SIGN_BIT],
                       exponent: ctrl_two_q[VOLT_EXP_LSB +: 3]};
    assign gain[1] = '{sign: ctrl_two_q[CUR1_SIGN_BIT],
                       exponent: ctrl_two_q[CUR1_EXP_LSB +: 3]};
    assign gain[2] = '{sign: ctrl_three_q[CUR2_SIGN_BIT],
                       exponent: ctrl_three_q[CUR2_EXP_LSB +: 3]};

    logic signed [OUT_W-1:0] chan_out [3];
    logic signed [SAMPLE_W-1:0] hp_out [3];
    logic valid_q;
    logic hp_valid_q;

    // Voltage and currents share the decimator geometry, so a loop builds all three.
    for (genvar c = 0; c < 3; c++) begin : g_chan
        logic signed [CIC_W-1:0]    int1_q;
        logic signed [CIC_W-1:0]    int2_q;
        logic signed [CIC_W-1:0]    int3_q;
        logic signed [CIC_W-1:0]    comb_in;
        logic signed [CIC_W-1:0]    d1_q;
        logic signed [CIC_W-1:0]    d2_q;
        logic signed [CIC_W-1:0]    d3_q;
        logic signed [CIC_W-1:0]    c1;
        logic signed [CIC_W-1:0]    c2;
        logic signed [CIC_W-1:0]    c3;
        logic signed [SAMPLE_W-1:0] dec_q;
        logic signed [SAMPLE_W-1:0] prev_q;
        logic signed [SAMPLE_W-1:0] hp_q;
        logic signed [SAMPLE_W-1:0] hp_sat;
        logic signed [SAMPLE_W+1:0] hp_d;
        logic [2:0]                 exp_clip;
        logic signed [OUT_W-1:0]    scaled;

        // Bipolar input: one is +1, zero is -1; a gated channel feeds -1 every clock and sits at negative full scale.
        assign comb_in = bits_gated[c] ? CIC_W'(1) : -CIC_W'(1);

        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                int1_q <= '0;
                int2_q <= '0;
                int3_q <= '0;
            end else begin
                int1_q <= int1_q + comb_in;
                int2_q <= int2_q + int1_q;
                int3_q <= int3_q + int2_q;
            end
        end

        assign c1 = int3_q - d1_q;
        assign c2 = c1 - d2_q;
        assign c3 = c2 - d3_q;

        // Comb delays advance only on the decimation tick.
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                d1_q <= '0;
                d2_q <= '0;
                d3_q <= '0;
            end else if (decim_tick) begin
                d1_q <= int3_q;
                d2_q <= c1;
                d3_q <= c2;
            end
        end

        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                dec_q <= '0;
            end else if (decim_tick) begin
                dec_q <= c3[CIC_W-1 -: SAMPLE_W];
            end
        end

        // First-order high-pass: y = x - x_prev + y - y/256, two guard bits wide.
        assign hp_d = (SAMPLE_W+2)'(dec_q) - (SAMPLE_W+2)'(prev_q)
                    + (SAMPLE_W+2)'(hp_q) - (SAMPLE_W+2)'(hp_q >>> 8);

        // A full-scale step would wrap a plain 24-bit result and flip its sign, so clamp it.
        always_comb begin
            if (hp_d[SAMPLE_W+1 -: 3] == 3'h0 || hp_d[SAMPLE_W+1 -: 3] == 3'h7) begin
                hp_sat = hp_d[SAMPLE_W-1:0];
            end else if (hp_d[SAMPLE_W+1]) begin
                hp_sat = {1'b1, {(SAMPLE_W-1){1'b0}}};
            end else begin
                hp_sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
            end
        end

        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                prev_q <= '0;
            end else if (valid_q) begin
                prev_q <= dec_q;
            end
        end

        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                hp_q <= '0;
            end else if (valid_q) begin
                hp_q <= hp_sat;
            end
        end

        assign hp_out[c] = hp_q;
        // Codes 6 and 7 are out of range and act as the largest gain.
        assign exp_clip  = (gain[c].exponent > EXP_MAX) ? EXP_MAX : gain[c].exponent;

        always_comb begin
            scaled = OUT_W'(hp_q) <<< exp_clip;
            if (c == 0 && ctrl_three_q[LPF_EN_BIT]) begin
                scaled = scaled >>> 2;
            end
        end

        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                chan_out[c] <= '0;
            end else begin
                chan_out[c] <= gain[c].sign ? -scaled : scaled;
            end
        end
    end

    // The pulse trails the gain register so that it marks the new sample, not the last.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= decim_tick;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hp_valid_q <= 1'b0;
        end else begin
            hp_valid_q <= valid_q;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_valid_o <= 1'b0;
        end else begin
            sample_valid_o <= hp_valid_q;
        end
    end

    assign volt_sample_o = chan_out[0];
    assign cur1_sample_o = chan_out[1];
    assign cur2_sample_o = chan_out[2];

    ////////////////////////////////////////////////////////////////////////////
    // Current detector

    logic [4:0]             run_cnt_q;
    logic [SAMPLE_W-1:0]    ac_mag;
    logic                   above;

    assign ac_mag = hp_out[1][SAMPLE_W-1] ? SAMPLE_W'(-hp_out[1]) : hp_out[1];
    assign above  = {8'h00, ac_mag} > threshold_q;

    assign set_caught = det_ctrl_q[DET_EN_BIT] && sample_valid_o && above &&
                        (run_cnt_q == {1'b0, det_ctrl_q[WIN_LEN_LSB +: 4]});

    // The run count saturates so a long run cannot wrap and fire again.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_cnt_q <= 5'h00;
        end else if (!det_ctrl_q[DET_EN_BIT]) begin
            run_cnt_q <= 5'h00;
        end else if (sample_valid_o) begin
            if (!above) begin
                run_cnt_q <= 5'h00;
            end else if (run_cnt_q != 5'h10) begin
                run_cnt_q <= run_cnt_q + 5'h01;
            end
        end
    end

endmodule
`default_nettype wire

// File: sim/mig_top_props.sv
// Assertion checker on the ports of the gain and detect block.
`timescale 1ns/100ps
`default_nettype none
module mig_top_props
    import mig_pkg::*;
(
    // Clock, reset and register bus
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Results
    input wire logic        sample_valid_o,
    input wire logic        power_rms_enable_o,
    input wire logic        current_caught_o
);
    logic       acc;
    logic       hit;
    logic       wr_det;
    logic       seen_q;
    logic [8:0] gap_q;
    assign acc = psel_i && penable_i;
    assign hit = paddr_i inside {32'h4008, 32'hA1E0, 32'hA1E4, 32'hA1E8, 32'hA218};
    assign wr_det = acc && pwrite_i && paddr_i == 32'hA218;
    ////////////////////////////////////////////////////////////////////////////
    // The first pulse after reset has no reference, so spacing is judged later.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_q <= 9'h000;
            seen_q <= 1'b0;
        end else if (sample_valid_o) begin
            gap_q <= 9'h000;
            seen_q <= 1'b1;
        end else if (gap_q != 9'h1FF) begin
            gap_q <= gap_q + 9'h001;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_zero_wait: assert property (acc |-> pready_o)
        else $error("pready low in access");
    a_decode_err: assert property (acc |-> pslverr_o == !hit)
        else $error("slave error wrong");
    a_sample_period: assert property (sample_valid_o && seen_q |-> gap_q == 9'h0FF)
        else $error("sample spacing wrong");
    a_sample_gap: assert property (seen_q |-> gap_q < 9'h100)
        else $error("sample overdue");
    a_power_follow: assert property (
        acc && pwrite_i && paddr_i == 32'hA1E0 |-> ##2 power_rms_enable_o == $past(pwdata_i[4], 2))
        else $error("power enable not following write");
    a_caught_cause: assert property (
        $rose(current_caught_o) |-> $past(sample_valid_o) || $past(sample_valid_o, 2))
        else $error("caught flag rose without sample");
    a_caught_hold: assert property (
        current_caught_o && !wr_det && !$past(wr_det) |=> current_caught_o)
        else $error("caught flag dropped");
    a_disable_clear: assert property (
        wr_det && !pwdata_i[4] && !sample_valid_o && !$past(sample_valid_o)
        |-> ##2 !current_caught_o [*4])
        else $error("caught flag kept while disabled");
endmodule
bind mig_top mig_top_props i_mig_top_props (
    .sys_clk_i          (sys_clk_i),
    .rstn_i             (rstn_i),
    .psel_i             (psel_i),
    .penable_i          (penable_i),
    .pwrite_i           (pwrite_i),
    .paddr_i            (paddr_i),
    .pwdata_i           (pwdata_i),
    .pready_o           (pready_o),
    .pslverr_o          (pslverr_o),
    .sample_valid_o     (sample_valid_o),
    .power_rms_enable_o (power_rms_enable_o),
    .current_caught_o   (current_caught_o)
);
`default_nettype wire

// File: sim/test_mig_top.sv
// Self-checking bench for the gain and detect block.
`timescale 1ns/100ps
`default_nettype none
module test_mig_top;
    import mig_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic        volt_bit_i = 1'b0;
    logic        cur1_bit_i = 1'b0;
    logic        cur2_bit_i = 1'b0;
    logic        inv_q = 1'b0;
    logic        pat;
    logic        err;
    logic [31:0] paddr_i = 32'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] cyc = 32'h0;
    logic [31:0] rd;
    logic [31:0] prdata_o, volt_sample_o, cur1_sample_o, cur2_sample_o;
    logic        pready_o, pslverr_o, sample_valid_o, power_rms_enable_o, current_caught_o;
    logic [31:0] adr [5] = '{32'h4008, 32'hA1E0, 32'hA1E4, 32'hA1E8, 32'hA218};
    int          mismatches = 0;
    int          total_checks = 0;
    mig_top i_mig_top (
        .sys_clk_i          (sys_clk_i),
        .rstn_i             (rstn_i),
        .psel_i             (psel_i),
        .penable_i          (penable_i),
        .pwrite_i           (pwrite_i),
        .paddr_i            (paddr_i),
        .pwdata_i           (pwdata_i),
        .prdata_o           (prdata_o),
        .pready_o           (pready_o),
        .pslverr_o          (pslverr_o),
        .volt_bit_i         (volt_bit_i),
        .cur1_bit_i         (cur1_bit_i),
        .cur2_bit_i         (cur2_bit_i),
        .volt_sample_o      (volt_sample_o),
        .cur1_sample_o      (cur1_sample_o),
        .cur2_sample_o      (cur2_sample_o),
        .sample_valid_o     (sample_valid_o),
        .power_rms_enable_o (power_rms_enable_o),
        .current_caught_o   (current_caught_o)
    );
    ////////////////////////////////////////////////////////////////////////////
    always #25 sys_clk_i = ~sys_clk_i;
    // Bit density steps every 2048 clocks so the high-pass output keeps moving.
    assign pat = cyc[11] ? (cyc[1:0] != 2'h0) : (cyc[1:0] == 2'h0);
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 32'h1;
        volt_bit_i <= pat;
        cur1_bit_i <= pat;
        cur2_bit_i <= pat ^ inv_q;
        if (cyc == 32'h3E80) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wrrd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
        apb(1'b1, a, d);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wait_valid(input int n);
        repeat (n) begin
            do @(negedge sys_clk_i); while (sample_valid_o !== 1'b1);
        end
    endtask
    task automatic t_regs();
        foreach (adr[i]) begin
            apb(1'b0, adr[i], 32'h0);
            chk(rd, 32'h0);
        end
        chk({31'h0, power_rms_enable_o}, 32'h0);
        apb(1'b0, 32'h0100, 32'h0);
        chk({31'h0, err}, 32'h1);
        wrrd(32'h4008, 32'h89AB_CDEF, 32'h89AB_CDEF);
        wrrd(32'hA1E4, 32'hF5, 32'hF5);
        wrrd(32'hA1E8, 32'h2D, 32'h2D);
        wrrd(32'hA218, 32'h3F, 32'h1F);
        wrrd(32'hA1E0, 32'h10, 32'h10);
        repeat (3) @(negedge sys_clk_i);
        chk({31'h0, power_rms_enable_o}, 32'h1);
        apb(1'b1, 32'hA218, 32'h0);
        $display("register test done");
    endtask
    // All three channels share one stream and one history, so their gains compare.
    task automatic t_gain();
        apb(1'b1, 32'hA1E0, 32'h17);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 32'hA1E4, 32'((k << 4) + k + 2));
            apb(1'b1, 32'hA1E8, 32'(8'h28 + k + 1));
            wait_valid(3);
            chk(cur2_sample_o, -(cur1_sample_o * 2));
            chk(volt_sample_o, cur1_sample_o);
        end
        apb(1'b1, 32'hA1E4, 32'h0D);
        apb(1'b1, 32'hA1E8, 32'h05);
        wait_valid(3);
        chk(cur2_sample_o, cur1_sample_o * 32);
        chk(volt_sample_o, -cur2_sample_o);
        chk({31'h0, cur1_sample_o != 32'h0}, 32'h1);
        $display("gain test done");
    endtask
    task automatic t_gate();
        apb(1'b1, 32'hA1E4, 32'h0);
        apb(1'b1, 32'hA1E8, 32'h0);
        apb(1'b1, 32'hA1E0, 32'h12);
        inv_q <= 1'b1;
        wait_valid(4);
        chk(volt_sample_o, cur2_sample_o);
        chk({31'h0, cur1_sample_o != volt_sample_o}, 32'h1);
        $display("gating test done");
    endtask
    task automatic t_detect();
        int n;
        apb(1'b1, 32'hA1E0, 32'h12);
        apb(1'b1, 32'h4008, 32'h0);
        wait_valid(1);
        apb(1'b1, 32'hA218, 32'h12);
        for (n = 1; n < 20; n++) begin
            wait_valid(1);
            repeat (3) @(negedge sys_clk_i);
            if (current_caught_o === 1'b1) break;
        end
        chk(n, 3);
        wait_valid(2);
        chk({31'h0, current_caught_o}, 32'h1);
        apb(1'b1, 32'hA218, 32'h32);
        repeat (3) @(negedge sys_clk_i);
        chk({31'h0, current_caught_o}, 32'h0);
        apb(1'b1, 32'h4008, 32'hFFFF_FFFF);
        apb(1'b1, 32'hA218, 32'h02);
        apb(1'b1, 32'hA218, 32'h12);
        wait_valid(6);
        chk({31'h0, current_caught_o}, 32'h0);
        $display("detect test done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        t_regs();
        t_gain();
        t_gate();
        t_detect();
        final_report();
    end
endmodule
`default_nettype wire
